/* verilog/sesu_unit.sv */
// Standard event status register bank with enable mask and summary bit
// How it works
// - Eight-bit enable mask, written by the enable command, reset to zero.
// - Summary output is OR of event bits whose mask bits are set.
// - Event and mask share layout: bits 5,4,3,2,0 used; 7,6,1 unused.
// - Event query returns flags and clears every flag not set again in the same cycle.
// - Error codes 100 to 199 set the command error flag.
// - Error codes 200 to 299 set the execution error flag.
// - Codes 300 to 399, or current/voltage error with questionable bit, set device flag.
// - Error codes 400 to 499 set the query error flag.
// - Clear-status clears events, operation, questionable and status byte; masks kept.
// - Clear-status empties the error queue and idles completion tracking.
// - Mask query returns the stored mask without changing it.
// - Completion command clears bit 0; sets it when pending work finishes.
`timescale 1ns/1ps
module sesu_unit
  import sesu_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // Command strobe from the parser
  input wire sesu_req_s req_in,
  // Error reports
  input wire sesu_err_s err_in,
  input wire logic meas_err_in,
  input wire logic ques_bit_in,
  // Pending work indicator from the rest of the device
  input wire logic busy_in,
  // Answers and status
  output sesu_rsp_s rsp_out,
  output logic esb_out,
  output logic [7:0] flags_out,
  output logic [7:0] mask_out,
  output logic opc_wait_out,
  output logic clear_status_out
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [7:0] event_enable_mask;
  logic [7:0] standard_event_flags;
  logic esb;
  sesu_rsp_s rsp;
  sesu_opc_e opc_state;
  logic clr_pulse;
  logic opc_wait;
  logic [7:0] next_event_enable_mask;
  logic [7:0] next_standard_event_flags;
  logic next_esb;
  sesu_rsp_s next_rsp;
  sesu_opc_e next_opc_state;
  logic next_clr_pulse;
  logic next_opc_wait;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;
  logic is_cls;
  logic is_esr;
  logic is_opc;

  // ------------------------------------------------------------
  // Event sources
  // ------------------------------------------------------------
  // Decode error classes and commands into per-bit set and clear terms
  always_comb begin
    set_bits = 8'h00;
    is_cls = req_in.valid && (req_in.cmd == SESU_CMD_CLS);
    is_esr = req_in.valid && (req_in.cmd == SESU_CMD_ESR_RD);
    is_opc = req_in.valid && (req_in.cmd == SESU_CMD_OPC);
    if (err_in.valid) begin
      if (err_in.code >= SESU_CLASS_100 && err_in.code < SESU_CLASS_200) begin
        set_bits[SESU_BIT_CME] = 1'b1;
      end else if (err_in.code >= SESU_CLASS_200 && err_in.code < SESU_CLASS_300) begin
        set_bits[SESU_BIT_EXE] = 1'b1;
      end else if (err_in.code >= SESU_CLASS_300 && err_in.code < SESU_CLASS_400) begin
        set_bits[SESU_BIT_DDE] = 1'b1;
      end else if (err_in.code >= SESU_CLASS_400 && err_in.code < SESU_CLASS_500) begin
        set_bits[SESU_BIT_QUE] = 1'b1;
      end
    end
    if (meas_err_in && ques_bit_in) begin
      set_bits[SESU_BIT_DDE] = 1'b1;
    end
    // Completion lands when waiting and work has drained
    if (opc_state == SESU_OPC_WAIT && !busy_in && !is_cls && !is_opc) begin
      set_bits[SESU_BIT_OPC] = 1'b1;
    end
    set_bits = set_bits & SESU_USED_MASK;
    // Read and clear-status wipe everything; completion command wipes bit 0
    clr_bits = (is_cls || is_esr) ? 8'hff : 8'h00;
    if (is_opc) begin
      clr_bits[SESU_BIT_OPC] = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Next values for flags, mask, summary, answers, tracker
  // ------------------------------------------------------------
  // New events win over a clear in the same cycle, so none is lost
  always_comb begin
    next_standard_event_flags = (standard_event_flags & ~clr_bits) | set_bits;
    next_event_enable_mask = event_enable_mask;
    if (req_in.valid && req_in.cmd == SESU_CMD_ESE_WR) begin
      next_event_enable_mask = req_in.data & SESU_USED_MASK;
    end
    // Summary computed from next values so it moves with them
    next_esb = |(next_standard_event_flags & next_event_enable_mask);
    next_rsp = '0;
    if (req_in.valid && req_in.cmd == SESU_CMD_ESE_RD) begin
      next_rsp.valid = 1'b1;
      next_rsp.data = event_enable_mask;
    end else if (is_esr) begin
      next_rsp.valid = 1'b1;
      next_rsp.data = standard_event_flags;
    end
    next_opc_state = opc_state;
    case (opc_state)
      SESU_OPC_IDLE: begin
        if (is_opc) begin
          next_opc_state = SESU_OPC_WAIT;
        end
      end
      SESU_OPC_WAIT: begin
        if (!busy_in) begin
          next_opc_state = SESU_OPC_IDLE;
        end
      end
      default: begin
        next_opc_state = SESU_OPC_IDLE;
      end
    endcase
    if (is_opc) begin
      next_opc_state = SESU_OPC_WAIT;
    end
    if (is_cls) begin
      next_opc_state = SESU_OPC_IDLE;
    end
    // Pulse tells the status byte, queue and other event registers to clear
    next_clr_pulse = is_cls;
    // Waiting flag kept in its own flop so the output needs no decode
    next_opc_wait = (next_opc_state == SESU_OPC_WAIT);
  end

  // Register stage
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      event_enable_mask <= SESU_MASK_RESET;
      standard_event_flags <= SESU_FLAGS_RESET;
      esb <= 1'b0;
      rsp <= '0;
      opc_state <= SESU_OPC_IDLE;
      clr_pulse <= 1'b0;
      opc_wait <= 1'b0;
    end else begin
      event_enable_mask <= next_event_enable_mask;
      standard_event_flags <= next_standard_event_flags;
      esb <= next_esb;
      rsp <= next_rsp;
      opc_state <= next_opc_state;
      clr_pulse <= next_clr_pulse;
      opc_wait <= next_opc_wait;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign rsp_out = rsp;
  assign esb_out = esb;
  assign flags_out = standard_event_flags;
  assign mask_out = event_enable_mask;
  assign opc_wait_out = opc_wait;
  assign clear_status_out = clr_pulse;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  a_mask_write: assert property (
    req_in.valid && req_in.cmd == SESU_CMD_ESE_WR |=> mask_out == ($past(req_in.data) & 8'h3d))
    else $error("mask not written");
  a_esb_or: assert property (
    esb_out == |(flags_out & mask_out))
    else $error("summary mismatch");
  a_unused_zero: assert property (
    (flags_out & 8'hc2) == 8'h00 && (mask_out & 8'hc2) == 8'h00)
    else $error("unused bit set");
  a_esr_read: assert property (
    is_esr && !err_in.valid && !meas_err_in |=> rsp_out.valid && rsp_out.data == $past(flags_out)
      && flags_out[5:1] == 5'h00)
    else $error("event read wrong");
  a_cme_set: assert property (
    err_in.valid && err_in.code >= 10'h064 && err_in.code <= 10'h0c7 |=> flags_out[5])
    else $error("command error missing");
  a_exe_set: assert property (
    err_in.valid && err_in.code >= 10'h0c8 && err_in.code <= 10'h12b |=> flags_out[4])
    else $error("execution error missing");
  a_dde_set: assert property (
    (err_in.valid && err_in.code >= 10'h12c && err_in.code <= 10'h18f)
      || (meas_err_in && ques_bit_in) |=> flags_out[3])
    else $error("device error missing");
  a_que_set: assert property (
    err_in.valid && err_in.code >= 10'h190 && err_in.code <= 10'h1f3 |=> flags_out[2])
    else $error("query error missing");
  a_cls_keeps: assert property (
    is_cls && !err_in.valid && !meas_err_in |=> flags_out == 8'h00 && clear_status_out
      && $stable(mask_out))
    else $error("clear status wrong");
  a_cls_idle: assert property (
    is_cls |=> !opc_wait_out)
    else $error("tracker not idle");
  a_ese_query: assert property (
    req_in.valid && req_in.cmd == SESU_CMD_ESE_RD |=> rsp_out.data == mask_out && $stable(mask_out))
    else $error("mask query wrong");
  a_opc_done: assert property (
    opc_wait_out && !busy_in && !req_in.valid |=> flags_out[0] && !opc_wait_out)
    else $error("completion not flagged");
  a_flags_sticky: assert property (
    !is_cls && !is_esr && !is_opc |=> (flags_out & $past(flags_out)) == $past(flags_out))
    else $error("flag dropped");

  c_cme_esb: cover property (err_in.valid && err_in.code == 10'h064 ##1 esb_out);
  c_esr_clear: cover property (is_esr ##1 flags_out == 8'h00);
  c_opc_cycle: cover property (is_opc ##1 opc_wait_out ##1 flags_out[0]);
  c_cls: cover property (is_cls ##1 clear_status_out);

endmodule : sesu_unit

/* inc/sesu_pkg.sv */
// Package for the standard event status unit: bit positions, commands, error classes
package sesu_pkg;

  // ------------------------------------------------------------
  // Event register layout
  // ------------------------------------------------------------
  localparam int unsigned SESU_BIT_CME = 5;
  localparam int unsigned SESU_BIT_EXE = 4;
  localparam int unsigned SESU_BIT_DDE = 3;
  localparam int unsigned SESU_BIT_QUE = 2;
  localparam int unsigned SESU_BIT_OPC = 0;
  localparam logic [7:0] SESU_USED_MASK = 8'h3d;
  localparam logic [7:0] SESU_MASK_RESET = 8'h00;
  localparam logic [7:0] SESU_FLAGS_RESET = 8'h00;
  localparam int unsigned SESU_ESB_BIT = 5;

  // ------------------------------------------------------------
  // Error code classes (hundreds digit of the reported code)
  // ------------------------------------------------------------
  localparam logic [9:0] SESU_CLASS_100 = 10'h064;
  localparam logic [9:0] SESU_CLASS_200 = 10'h0c8;
  localparam logic [9:0] SESU_CLASS_300 = 10'h12c;
  localparam logic [9:0] SESU_CLASS_400 = 10'h190;
  localparam logic [9:0] SESU_CLASS_500 = 10'h1f4;

  // ------------------------------------------------------------
  // Common commands from the remote-interface parser
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    SESU_CMD_NONE = 3'h0,
    SESU_CMD_ESE_WR = 3'h1,
    SESU_CMD_ESE_RD = 3'h2,
    SESU_CMD_ESR_RD = 3'h3,
    SESU_CMD_CLS = 3'h4,
    SESU_CMD_OPC = 3'h5
  } sesu_cmd_e;

  // Command strobe with its data
  typedef struct packed {
    logic valid;
    sesu_cmd_e cmd;
    logic [7:0] data;
  } sesu_req_s;

  // Error report from the parser or the device
  typedef struct packed {
    logic valid;
    logic [9:0] code;
  } sesu_err_s;

  // Query answer
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } sesu_rsp_s;

  // Operation-complete tracker states, one-hot
  typedef enum logic [1:0] {
    SESU_OPC_IDLE = 2'b01,
    SESU_OPC_WAIT = 2'b10
  } sesu_opc_e;

endpackage : sesu_pkg

/* sim/sesu_host.sv */
// Host controller model issuing common commands and taking the answers
`timescale 1ns/1ps
module sesu_host
  import sesu_pkg::*;
(
  // Clock
  input wire logic clk_sys_in,
  // Command strobe out, answer in
  output sesu_req_s req_out,
  input wire sesu_rsp_s rsp_in
);
  initial req_out = '0;
  // One-cycle strobe; answer taken at the next falling edge, after the taking edge
  task automatic issue(input sesu_cmd_e cmd, input logic [7:0] data, output sesu_rsp_s rsp);
    @(negedge clk_sys_in);
    req_out = '{valid: 1'b1, cmd: cmd, data: data};
    @(negedge clk_sys_in);
    rsp = rsp_in;
    // Released lines show the inverse so stale data is never mistaken for a request
    req_out = {1'b0, ~req_out[10:0]};
  endtask : issue
endmodule : sesu_host

/* sim/tb_top.sv */
// Self-checking bench for the standard event status unit
`timescale 1ns/1ps
module tb_top;
  import sesu_pkg::*;
  logic clk_sys_in;
  logic reset_n_in;
  sesu_req_s req;
  sesu_err_s err;
  logic meas_err;
  logic ques_bit;
  logic busy;
  sesu_rsp_s rsp;
  logic esb;
  logic opc_wait;
  logic clr;
  logic [7:0] flags;
  logic [7:0] mask;
  int fails = 0;
  int checked = 0;
  // Error codes at the class edges and the flag each should raise
  localparam logic [9:0] CODES [10] = '{10'h064, 10'h0c7, 10'h0c8, 10'h12b, 10'h12c,
    10'h18f, 10'h190, 10'h1f3, 10'h1f4, 10'h063};
  localparam logic [7:0] BITS [10] = '{8'h20, 8'h20, 8'h10, 8'h10, 8'h08, 8'h08,
    8'h04, 8'h04, 8'h00, 8'h00};
  // ------------------------------------------------------------
  // Clock, design and host
  // ------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  sesu_unit u_dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .req_in(req),
    .err_in(err), .meas_err_in(meas_err), .ques_bit_in(ques_bit), .busy_in(busy),
    .rsp_out(rsp), .esb_out(esb), .flags_out(flags), .mask_out(mask),
    .opc_wait_out(opc_wait), .clear_status_out(clr));
  sesu_host u_host (.clk_sys_in(clk_sys_in), .req_out(req), .rsp_in(rsp));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Command with the expected answer; no answer expected for plain commands
  task automatic op(input sesu_cmd_e c, input logic [7:0] d, input logic v,
                    input logic [7:0] e);
    sesu_rsp_s r;
    u_host.issue(c, d, r);
    chk("answer valid", {7'h00, v}, {7'h00, r.valid});
    if (v) begin
      chk("answer data", e, r.data);
    end
  endtask : op
  // One-cycle error report; code lines inverted once released
  task automatic report(input logic [9:0] code);
    @(negedge clk_sys_in);
    err = '{valid: 1'b1, code: code};
    @(negedge clk_sys_in);
    err = '{valid: 1'b0, code: ~code};
  endtask : report
  task automatic summarize();
    if (fails == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    reset_n_in = 1'b0;
    err = '0;
    meas_err = 1'b0;
    ques_bit = 1'b0;
    busy = 1'b0;
    repeat (5) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    chk("mask", 8'h00, mask);
    op(SESU_CMD_ESE_RD, 8'h00, 1'b1, 8'h00);
    op(SESU_CMD_ESE_WR, 8'hff, 1'b0, 8'h00);
    chk("mask", 8'h3d, mask);
    op(SESU_CMD_ESE_RD, 8'h00, 1'b1, 8'h3d);
    op(SESU_CMD_ESE_RD, 8'h00, 1'b1, 8'h3d);
    op(sesu_cmd_e'(3'h7), 8'h00, 1'b0, 8'h00);
    // Each class edge from 100 to 499 raises one flag, codes 500 and 99 none; the read returns and clears it
    for (int i = 0; i < 10; i++) begin
      report(CODES[i]);
      chk("summary", {7'h00, BITS[i] != 8'h00}, {7'h00, esb});
      op(SESU_CMD_ESR_RD, 8'h00, 1'b1, BITS[i]);
      chk("flags", 8'h00, flags);
    end
    // Measurement error needs its questionable bit as well
    @(negedge clk_sys_in);
    meas_err = 1'b1;
    @(negedge clk_sys_in);
    chk("flags", 8'h00, flags);
    ques_bit = 1'b1;
    @(negedge clk_sys_in);
    meas_err = 1'b0;
    ques_bit = 1'b0;
    chk("flags", 8'h08, flags);
    report(10'h064);
    chk("flags", 8'h28, flags);
    op(SESU_CMD_ESE_WR, 8'h10, 1'b0, 8'h00);
    chk("summary", 8'h00, {7'h00, esb});
    report(10'h0c8);
    chk("flags", 8'h38, flags);
    chk("summary", 8'h01, {7'h00, esb});
    op(SESU_CMD_CLS, 8'h00, 1'b0, 8'h00);
    chk("clear pulse", 8'h01, {7'h00, clr});
    chk("flags", 8'h00, flags);
    chk("mask", 8'h10, mask);
    chk("summary", 8'h00, {7'h00, esb});
    // Completion with nothing pending, then with work pending
    op(SESU_CMD_OPC, 8'h00, 1'b0, 8'h00);
    chk("waiting", 8'h01, {7'h00, opc_wait});
    @(negedge clk_sys_in);
    chk("flags", 8'h01, flags);
    busy = 1'b1;
    op(SESU_CMD_OPC, 8'h00, 1'b0, 8'h00);
    repeat (3) @(negedge clk_sys_in);
    chk("flags", 8'h00, flags);
    busy = 1'b0;
    @(negedge clk_sys_in);
    chk("flags", 8'h01, flags);
    // Clear-status while waiting must idle the tracker without setting the flag
    busy = 1'b1;
    op(SESU_CMD_OPC, 8'h00, 1'b0, 8'h00);
    op(SESU_CMD_CLS, 8'h00, 1'b0, 8'h00);
    chk("waiting", 8'h00, {7'h00, opc_wait});
    busy = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    chk("flags", 8'h00, flags);
    summarize();
  end
endmodule : tb_top
